// File: sdram_pin_command_interface_tb.sv
// Testbench joining controller and device ends, driven over APB.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_command_interface_tb;
  import spc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, refresh, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd, q;
  logic [11:0] mode, op;
  logic [3:0] banks, exp_banks;
  logic [15:0] d1, d2;
  logic [1:0] m;
  spc_state_e state;
  int errors, total_checks, refresh_cnt;
  spc_if u_spc_if ();
  spc_ctl u_spc_ctl (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PINS(u_spc_if));
  spc_dev u_spc_dev (.REF_CLK_I(clk), .RST_N_I(rst_n), .PINS(u_spc_if), .STATE_O(state),
    .MODE_O(mode), .OPEN_BANKS_O(banks), .REFRESH_O(refresh));
  spc_checker u_spc_checker (.REF_CLK_I(clk), .RST_N_I(rst_n), .clk_gate(u_spc_if.clk_gate),
    .chip_sel_n(u_spc_if.chip_sel_n), .strobe_n(u_spc_if.strobe_n),
    .low_byte_mask(u_spc_if.low_byte_mask), .high_byte_mask(u_spc_if.high_byte_mask),
    .ctl_data(u_spc_if.ctl_data), .ctl_data_oe(u_spc_if.ctl_data_oe),
    .dev_data_oe(u_spc_if.dev_data_oe), .data_lines(u_spc_if.data_lines));
  // Clock of 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts the auto refresh pulses of the device.
  always @(posedge clk) begin
    if (refresh === 1'b1) begin
      refresh_cnt <= refresh_cnt + 1;
    end
  end
  // Next pseudo-random word.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Read word expected after a full write, a masked write and a masked read.
  function automatic logic [31:0] exp_read(input logic [15:0] a, input logic [15:0] b,
      input logic [1:0] wm, input logic [1:0] rm);
    logic [15:0] s;
    s = {wm[1] ? a[15:8] : b[15:8], wm[0] ? a[7:0] : b[7:0]};
    return {15'h0, 1'b1, rm[1] ? 8'h00 : s[15:8], rm[0] ? 8'h00 : s[7:0]};
  endfunction
  // Compares a word and counts the result.
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compares the device state and counts the result.
  task automatic check_state(input spc_state_e exp);
    total_checks++;
    if (state !== exp) begin
      errors++;
      $display("Error state expected %0d seen %0d", exp, state);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for an idle controller, then drives one command on the pins.
  task automatic cmd(input logic [2:0] s, input logic [1:0] b, input logic [1:0] wm,
      input logic [11:0] a, input logic sel);
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
    apb(1'b1, REG_ADDR, {20'h0, a});
    apb(1'b1, REG_CMD, {24'h0, wm, b, sel, s});
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Polls the read data register until its valid flag is set.
  task automatic read_data();
    do begin
      apb(1'b0, REG_RDATA, 32'h0);
    end while (rd[F_RVALID] !== 1'b1);
    q = rd;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    final_report();
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'hB0D64B88;
    errors = 0;
    total_checks = 0;
    exp_banks = 4'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_GATE, 32'h0);
    check_word("gate reset", 32'h1, rd);
    check_state(DEV_ACTIVE);
    apb(1'b0, 8'h3C, 32'h0);
    check_word("unmapped error", 32'h1, {31'h0, err});
    check_word("unmapped data", 32'h0, rd);
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      op = seed[11:0];
      cmd(3'h0, 2'h0, 2'h0, op, 1'b1);
      check_word("mode", {20'h0, op}, {20'h0, mode});
    end
    cmd(3'h0, 2'h0, 2'h0, ~op, 1'b0);
    check_word("mode inhibit", {20'h0, op}, {20'h0, mode});
    cmd(3'h7, 2'h1, 2'h0, 12'h000, 1'b1);
    cmd(3'h6, 2'h2, 2'h0, 12'h000, 1'b1);
    check_word("banks idle", 32'h0, {28'h0, banks});
    $display("Test mode done");
    for (int b = 0; b < 4; b++) begin
      seed = lfsr(seed);
      cmd(3'h3, b[1:0], 2'h0, seed[11:0], 1'b1);
      exp_banks[b] = 1'b1;
      check_word("banks open", {28'h0, exp_banks}, {28'h0, banks});
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        d1 = seed[15:0];
        d2 = seed[31:16];
        m = seed[9:8];
        apb(1'b1, REG_WDATA, {16'h0, d1});
        cmd(3'h4, b[1:0], 2'h0, {4'h0, seed[23:16]}, 1'b1);
        apb(1'b1, REG_WDATA, {16'h0, d2});
        cmd(3'h4, b[1:0], m, {4'h0, seed[23:16]}, 1'b1);
        cmd(3'h5, b[1:0], i[1:0], {4'h0, seed[23:16]}, 1'b1);
        read_data();
        check_word("read data", exp_read(d1, d2, m, i[1:0]), q);
      end
    end
    $display("Test data done");
    cmd(3'h5, 2'h0, 2'h0, 12'h455, 1'b1);
    read_data();
    cmd(3'h4, 2'h1, 2'h3, 12'h4AA, 1'b1);
    exp_banks[1:0] = 2'h0;
    check_word("auto close", {28'h0, exp_banks}, {28'h0, banks});
    cmd(3'h2, 2'h2, 2'h0, 12'h000, 1'b1);
    exp_banks[2] = 1'b0;
    check_word("close one", {28'h0, exp_banks}, {28'h0, banks});
    cmd(3'h3, 2'h0, 2'h0, 12'h001, 1'b1);
    cmd(3'h2, 2'h1, 2'h0, 12'h400, 1'b1);
    check_word("close all", 32'h0, {28'h0, banks});
    cmd(3'h1, 2'h0, 2'h0, 12'h000, 1'b1);
    cmd(3'h1, 2'h3, 2'h0, 12'hFFF, 1'b1);
    check_word("refresh count", 32'h2, refresh_cnt);
    $display("Test close done");
    apb(1'b1, REG_GATE, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check_state(DEV_PWRDN);
    cmd(3'h0, 2'h0, 2'h0, ~op, 1'b1);
    check_word("mode gated", {20'h0, op}, {20'h0, mode});
    apb(1'b1, REG_GATE, 32'h1);
    cmd(3'h3, 2'h3, 2'h0, 12'h123, 1'b1);
    check_state(DEV_ACTIVE);
    apb(1'b1, REG_GATE, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check_state(DEV_SUSPEND);
    apb(1'b1, REG_GATE, 32'h1);
    apb(1'b1, REG_CMD, 32'h0000_0109);
    repeat (2) @(posedge clk);
    #1;
    check_state(DEV_SELFREF);
    check_word("no auto refresh", 32'h2, refresh_cnt);
    apb(1'b1, REG_GATE, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    check_state(DEV_ACTIVE);
    $display("Test gate done");
    final_report();
  end
endmodule
`default_nettype wire

// File: spc_checker.sv
// Concurrent checks on the pins between the controller and device ends.
// Assumes one shared clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module spc_checker (
  input wire logic REF_CLK_I,  // Shared clock.
  input wire logic RST_N_I,  // Reset, active low.
  input wire logic clk_gate,  // Clock-gate level.
  input wire logic chip_sel_n,  // Chip select, active low.
  input wire logic [2:0] strobe_n,  // Command strobes.
  input wire logic low_byte_mask,  // Mask of bits 7..0.
  input wire logic high_byte_mask,  // Mask of bits 15..8.
  input wire logic [spc_pkg::DATA_W-1:0] ctl_data,  // Controller data.
  input wire logic ctl_data_oe,  // Controller drives data.
  input wire logic [1:0] dev_data_oe,  // Device drives each byte.
  input wire logic [spc_pkg::DATA_W-1:0] data_lines  // Resolved data lines.
);
  import spc_pkg::*;
  wire logic rd_cmd;  // A read stands on the pins.
  wire logic wr_cmd;  // A write stands on the pins.
  assign rd_cmd = !chip_sel_n && strobe_n == 3'h5;
  assign wr_cmd = !chip_sel_n && strobe_n == 3'h4;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ************************************************************
  // Assertions on the pins.
  // ************************************************************
  chk_cmd_one_cycle: assert property (!chip_sel_n |=> chip_sel_n)
    else $error("command held longer than one cycle");
  chk_write_drive: assert property (ctl_data_oe == wr_cmd)
    else $error("controller data drive not tied to a write");
  chk_write_lines: assert property (ctl_data_oe |-> data_lines == ctl_data)
    else $error("write data not on the lines in the command cycle");
  chk_read_lo_float: assert property ((rd_cmd && low_byte_mask && clk_gate) |->
    ##2 !dev_data_oe[0]) else $error("masked low byte driven on read");
  chk_read_hi_float: assert property ((rd_cmd && high_byte_mask && clk_gate) |->
    ##2 !dev_data_oe[1]) else $error("masked high byte driven on read");
  chk_drive_lo_cause: assert property (dev_data_oe[0] |->
    $past(rd_cmd, 2) && !$past(low_byte_mask, 2)) else $error("low byte driven without cause");
  chk_drive_hi_cause: assert property (dev_data_oe[1] |->
    $past(rd_cmd, 2) && !$past(high_byte_mask, 2)) else $error("high byte driven without cause");
  chk_gate_spacing: assert property ($changed(clk_gate) |=> $stable(clk_gate))
    else $error("clock gate toggled on consecutive edges");
  // Main scenarios seen.
  cov_read: cover property (rd_cmd && !low_byte_mask && !high_byte_mask);
  cov_write: cover property (wr_cmd && low_byte_mask);
  cov_gate_low: cover property ($fell(clk_gate));
endmodule
`default_nettype wire

// File: spc_ctl.sv
// Controller end: software fills registers over APB and a write to the
// command register, when no read is outstanding, drives one command on the pins for one clock.
// Assumes a zero-wait APB master on the same clock as the pins.
`timescale 1ns/1ps
`default_nettype none
module spc_ctl (
  input wire logic REF_CLK_I,  // Clock of both ends.
  input wire logic RST_N_I,  // Asynchronous reset, active low.
  input wire logic PSEL_I,  // APB select.
  input wire logic PENABLE_I,  // APB access phase.
  input wire logic PWRITE_I,  // APB direction.
  input wire logic [7:0] PADDR_I,  // APB byte address.
  input wire logic [31:0] PWDATA_I,  // APB write data.
  output logic [31:0] PRDATA_O,  // APB read data.
  output logic PREADY_O,  // APB ready.
  output logic PSLVERR_O,  // APB error for unmapped addresses.
  spc_if.ctl PINS  // Pin bundle.
);
  import spc_pkg::*;

  // ************************************************************
  // Bus decode.
  // ************************************************************
  wire logic acc = PSEL_I && PENABLE_I;  // Access phase edge.
  wire logic setup = PSEL_I && !PENABLE_I;  // Setup phase edge.
  wire logic mapped = PADDR_I == REG_CMD || PADDR_I == REG_ADDR
    || PADDR_I == REG_WDATA || PADDR_I == REG_RDATA
    || PADDR_I == REG_STATUS || PADDR_I == REG_GATE;
  logic [1:0] lat;  // Clocks left until read data is sampled.
  wire logic busy = lat != 2'h0;  // A read is still outstanding.
  wire logic issue = acc && PWRITE_I && PADDR_I == REG_CMD && !busy;
  wire logic [2:0] strobe = PWDATA_I[F_STROBE +: 3];
  wire logic is_read = PWDATA_I[F_SELECT] && strobe == 3'h5;
  wire logic is_write = PWDATA_I[F_SELECT] && strobe == 3'h4;
  logic [DATA_W-1:0] wdata;  // Data for the next write command.
  logic [DATA_W-1:0] rdata;  // Last sampled read data.
  logic rvalid;  // Read data waits for software.
  wire logic rd_clear = acc && !PWRITE_I && PADDR_I == REG_RDATA;

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc && !mapped;

  // Read data is registered in the setup phase and stands in the access.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= '0;
    end else if (setup && !PWRITE_I) begin
      case (PADDR_I)
        REG_ADDR: PRDATA_O <= 32'(PINS.address_inputs);
        REG_WDATA: PRDATA_O <= 32'(wdata);
        REG_RDATA: PRDATA_O <= 32'({rvalid, rdata});
        REG_STATUS: PRDATA_O <= 32'(busy);
        REG_GATE: PRDATA_O <= 32'(PINS.clk_gate);
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Registers that stand on the pins.
  // ************************************************************
  // Address, bank, masks and gate hold until software changes them.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PINS.address_inputs <= '0;
      PINS.bank_select <= '0;
      PINS.low_byte_mask <= MASK_RST[0];
      PINS.high_byte_mask <= MASK_RST[1];
      PINS.clk_gate <= GATE_RST;
      wdata <= '0;
    end else if (acc && PWRITE_I) begin
      if (PADDR_I == REG_ADDR) begin
        PINS.address_inputs <= PWDATA_I[ADDR_W-1:0];
      end
      if (PADDR_I == REG_WDATA) begin
        wdata <= PWDATA_I[DATA_W-1:0];
      end
      if (PADDR_I == REG_GATE) begin
        PINS.clk_gate <= PWDATA_I[0];
      end
      if (issue) begin
        PINS.bank_select <= PWDATA_I[F_BANK +: BANK_W];
        PINS.low_byte_mask <= PWDATA_I[F_MASK];
        PINS.high_byte_mask <= PWDATA_I[F_MASK + 1];
        // Dropping the gate with the command itself is the only way to
        // register a refresh while the gate is low, so with a refresh command this enters self-refresh.
        if (PWDATA_I[F_GATE_CMD]) begin
          PINS.clk_gate <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // One-clock command drive.
  // ************************************************************
  // The command stands for one clock, then the chip is deselected.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PINS.chip_sel_n <= 1'b1;
      PINS.strobe_n <= 3'h7;
      PINS.ctl_data <= '0;
      PINS.ctl_data_oe <= 1'b0;
    end else begin
      PINS.chip_sel_n <= !(issue && PWDATA_I[F_SELECT]);
      PINS.strobe_n <= issue ? strobe : 3'h7;
      PINS.ctl_data <= wdata;
      PINS.ctl_data_oe <= issue && is_write;
    end
  end

  // ************************************************************
  // Read capture.
  // ************************************************************
  // Data is sampled two clocks after the device registers the read.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lat <= 2'h0;
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      if (issue && is_read) begin
        lat <= 2'(READ_LAT + 1);
      end else if (busy) begin
        lat <= lat - 2'h1;
      end
      if (lat == 2'h1) begin
        rdata <= PINS.data_lines;
      end
      rvalid <= (lat == 2'h1) || (rvalid && !rd_clear);
    end
  end

endmodule
`default_nettype wire

// File: spc_dev.sv
// Device end: samples commands on the pins, keeps bank state, a small
// store, the mode word, and drives read data under the byte masks.
// Assumes the controller end drives the pins from the same clock.
`timescale 1ns/1ps
`default_nettype none
module spc_dev #(
  parameter int STORE_ROW_W = 4  // Low row bits that address the store.
) (
  input wire logic REF_CLK_I,  // Clock of both ends.
  input wire logic RST_N_I,  // Asynchronous reset, active low.
  spc_if.dev PINS,  // Pin bundle.
  output var spc_pkg::spc_state_e STATE_O,  // Active or one of three gated states.
  output logic [spc_pkg::ADDR_W-1:0] MODE_O,  // Last loaded op-code.
  output logic [3:0] OPEN_BANKS_O,  // One bit per bank with an open row.
  output logic REFRESH_O  // One-cycle pulse per auto refresh.
);
  import spc_pkg::*;

  // ************************************************************
  // Sampling and decoding.
  // ************************************************************
  localparam int IDX_W = BANK_W + STORE_ROW_W + COL_W;  // Store index width.
  localparam int DEPTH = 1 << IDX_W;  // Store words.

  logic gate_prev;  // Gate level seen at the last edge.
  logic rd_vld;  // Read taken at the last counted edge.
  wire logic edge_ok = gate_prev;  // This edge counts.
  wire logic gate_now = PINS.clk_gate;  // Gate level at this edge.
  spc_cmd_e cmd;  // Command decoded at this edge.
  assign cmd = spc_decode(PINS.chip_sel_n, PINS.strobe_n);
  wire logic [BANK_W-1:0] bank = PINS.bank_select;
  wire logic scope = PINS.address_inputs[SCOPE_BIT];  // Precharge scope bit.
  wire logic [1:0] mask = {PINS.high_byte_mask, PINS.low_byte_mask};
  wire logic take = edge_ok && gate_now;  // Normal command edge.
  wire logic do_open = take && cmd == CMD_OPEN;
  wire logic do_read = take && cmd == CMD_READ && OPEN_BANKS_O[bank];
  wire logic do_write = take && cmd == CMD_WRITE && OPEN_BANKS_O[bank];
  wire logic do_close = take && cmd == CMD_CLOSE;

  logic [ADDR_W-1:0] open_row [4];  // Open row of each bank.
  wire logic [IDX_W-1:0] idx = {bank, open_row[bank][STORE_ROW_W-1:0],
    PINS.address_inputs[COL_W-1:0]};
  logic [DATA_W-1:0] rd_word;  // Word at idx, assembled from byte lanes.

  // The gate level is kept in this flop for the next edge, but the command logic
  // also reads gate_now directly, so its timing against the clock reaches it.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gate_prev <= GATE_RST;
    end else begin
      gate_prev <= gate_now;
    end
  end

  // ************************************************************
  // Power state.
  // ************************************************************
  // Gate low on a counted edge picks the state; gate high returns to active.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      STATE_O <= DEV_ACTIVE;
    end else if (gate_now) begin
      STATE_O <= DEV_ACTIVE;
    end else if (edge_ok) begin
      case (1'b1)
        (cmd == CMD_REFRESH): STATE_O <= DEV_SELFREF;
        (OPEN_BANKS_O != 4'h0 || rd_vld): STATE_O <= DEV_SUSPEND;
        default: STATE_O <= DEV_PWRDN;
      endcase
    end
  end

  // Auto refresh fires when the refresh command meets a high gate.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REFRESH_O <= 1'b0;
    end else begin
      REFRESH_O <= take && cmd == CMD_REFRESH;
    end
  end

  // The mode word is loaded from the address inputs.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MODE_O <= '0;
    end else if (take && cmd == CMD_MODE) begin
      MODE_O <= PINS.address_inputs;
    end
  end

  // ************************************************************
  // Bank rows.
  // ************************************************************
  // Each bank opens on row-open and closes on row-close or auto precharge.
  for (genvar k = 0; k < 4; k++) begin : g_bank
    wire logic hit = bank == BANK_W'(k);
    wire logic shut = (do_close && (scope || hit))
      || ((do_read || do_write) && hit && scope);
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        OPEN_BANKS_O[k] <= 1'b0;
        open_row[k] <= '0;
      end else if (do_open && hit) begin
        OPEN_BANKS_O[k] <= 1'b1;
        open_row[k] <= PINS.address_inputs;
      end else if (shut) begin
        OPEN_BANKS_O[k] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Store, one array per byte lane.
  // ************************************************************
  for (genvar b = 0; b < 2; b++) begin : g_lane
    logic [7:0] mem [DEPTH];  // Byte lane store.
    assign rd_word[8*b +: 8] = mem[idx];
    // A masked byte is not written, so the stored byte stays.
    always_ff @(posedge REF_CLK_I) begin
      if (do_write && !mask[b]) begin
        mem[idx] <= PINS.data_lines[8*b +: 8];
      end
    end
  end

  // ************************************************************
  // Read pipeline.
  // ************************************************************
  logic [DATA_W-1:0] rd_hold;  // Its data.
  logic [1:0] mask_hold;  // Masks registered at that edge.

  // First stage: masks are registered on every counted edge.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_vld <= 1'b0;
      rd_hold <= '0;
      mask_hold <= MASK_RST;
    end else if (edge_ok) begin
      rd_vld <= do_read;
      rd_hold <= rd_word;
      mask_hold <= mask;
    end
  end

  // Second stage drives the lines, so a mask reaches the outputs one
  // counted edge after it was registered; a suspended clock holds it.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PINS.dev_data <= '0;
      PINS.dev_data_oe <= 2'h0;
    end else if (edge_ok) begin
      PINS.dev_data <= rd_hold;
      PINS.dev_data_oe <= {2{rd_vld}} & ~mask_hold;
    end
  end

endmodule
`default_nettype wire

// File: spc_if.sv
// Pin bundle between the DRAM device end and the controller end.
// Assumes both ends run on the same clock; data lines resolved here.
`timescale 1ns/1ps
`default_nettype none
interface spc_if;
  import spc_pkg::*;

  logic clk_gate;  // Clock-gate level from the controller.
  logic chip_sel_n;  // Chip select, active low.
  logic [2:0] strobe_n;  // Row, column and write strobes, active low.
  logic [ADDR_W-1:0] address_inputs;  // Row, column or op-code.
  logic [BANK_W-1:0] bank_select;  // Target bank.
  logic low_byte_mask;  // Gates data bits 7..0.
  logic high_byte_mask;  // Gates data bits 15..8.
  logic [DATA_W-1:0] ctl_data;  // Controller drive value.
  logic ctl_data_oe;  // Controller drives the data lines.
  logic [DATA_W-1:0] dev_data;  // Device drive value.
  logic [1:0] dev_data_oe;  // Device drives each byte.
  logic [DATA_W-1:0] data_lines;  // Resolved level of the data lines.

  // Each byte shows the device when it drives, else the controller, else zero.
  for (genvar b = 0; b < 2; b++) begin : g_res
    assign data_lines[8*b +: 8] = dev_data_oe[b] ? dev_data[8*b +: 8] :
                                  (ctl_data_oe ? ctl_data[8*b +: 8] : 8'h00);
  end

  modport dev (input clk_gate, chip_sel_n, strobe_n, address_inputs, bank_select,
    low_byte_mask, high_byte_mask, data_lines, output dev_data, dev_data_oe);
  modport ctl (output clk_gate, chip_sel_n, strobe_n, address_inputs, bank_select,
    low_byte_mask, high_byte_mask, ctl_data, ctl_data_oe, input data_lines);
endinterface
`default_nettype wire

// File: spc_pkg.sv
// Shared constants, types and command decoding for the DRAM pin interface.
// Assumes one clock for both ends and no other package.
package spc_pkg;

  // ************************************************************
  // Widths and timing.
  // ************************************************************
  localparam int ADDR_W = 12;  // Width of the address inputs.
  localparam int COL_W = 8;  // Width of the column field.
  localparam int BANK_W = 2;  // Width of the bank select.
  localparam int DATA_W = 16;  // Width of the data lines.
  localparam int SCOPE_BIT = 10;  // Position of the precharge scope bit.
  localparam int READ_LAT = 2;  // Clocks from read command to read data.

  // ************************************************************
  // Controller register map and fields.
  // ************************************************************
  localparam logic [7:0] REG_CMD = 8'h00;  // Strobes, select, bank, masks.
  localparam logic [7:0] REG_ADDR = 8'h04;  // Address inputs value.
  localparam logic [7:0] REG_WDATA = 8'h08;  // Write data for the next write.
  localparam logic [7:0] REG_RDATA = 8'h0C;  // Read data and valid flag.
  localparam logic [7:0] REG_STATUS = 8'h10;  // Busy flag.
  localparam logic [7:0] REG_GATE = 8'h14;  // Clock-gate level.
  localparam int F_STROBE = 0;  // Row, column, write strobe levels.
  localparam int F_SELECT = 3;  // One selects the chip for this command.
  localparam int F_BANK = 4;  // Bank select field.
  localparam int F_MASK = 6;  // Low and high byte masks.
  localparam int F_GATE_CMD = 8;  // One drops the clock gate with this command.
  localparam int F_RVALID = 16;  // Read data valid in the read data word.
  localparam logic GATE_RST = 1'b1;  // Clock gate is high after reset.
  localparam logic [1:0] MASK_RST = 2'h3;  // Both bytes masked after reset.

  // ************************************************************
  // Commands and device states.
  // ************************************************************
  typedef enum {CMD_INHIBIT, CMD_IDLE, CMD_OPEN, CMD_READ, CMD_WRITE, CMD_STOP,
    CMD_CLOSE, CMD_REFRESH, CMD_MODE} spc_cmd_e;
  typedef enum {DEV_ACTIVE, DEV_PWRDN, DEV_SUSPEND, DEV_SELFREF} spc_state_e;

  // Decodes the sampled strobes into a command.
  function automatic spc_cmd_e spc_decode(input logic cs_n, input logic [2:0] s);
    spc_cmd_e c;
    c = CMD_INHIBIT;
    if (!cs_n) begin
      case (s)
        3'h7: c = CMD_IDLE;
        3'h3: c = CMD_OPEN;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h6: c = CMD_STOP;
        3'h2: c = CMD_CLOSE;
        3'h1: c = CMD_REFRESH;
        default: c = CMD_MODE;
      endcase
    end
    return c;
  endfunction

endpackage
